// ==== inc/dacb_pkg.sv ====
// Package: register map, field positions, reset values and carrier types of the DAC bank
`default_nettype none
package dacb_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_IFACE_CFG     = 8'h01;
  localparam logic [7:0] ADDR_UPDATE        = 8'h0f;
  localparam logic [7:0] ADDR_CLR_EN_LO     = 8'h18;
  localparam logic [7:0] ADDR_CLR_EN_HI     = 8'h19;
  localparam logic [7:0] ADDR_CLR_SRC_LO    = 8'h1a;
  localparam logic [7:0] ADDR_CLR_SRC_HI    = 8'h1b;
  localparam logic [7:0] ADDR_RANGE         = 8'h1e;
  localparam logic [7:0] ADDR_CODE_FIRST    = 8'h50;
  localparam logic [7:0] ADDR_CODE_LAST     = 8'h67;
  localparam logic [7:0] ADDR_ALARM_STAT_LO = 8'h74;
  localparam logic [7:0] ADDR_ALARM_STAT_HI = 8'h75;
  localparam logic [7:0] ADDR_SW_CLR_LO     = 8'hb0;
  localparam logic [7:0] ADDR_SW_CLR_HI     = 8'hb1;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int         READ_SEL_BIT   = 1;     // 1 = read active, 0 = read buffer
  localparam int         UPDATE_BIT     = 0;     // Write 1 to move buffer to active
  localparam logic [7:0] RST_BYTE       = 8'h00;
  localparam logic [11:0] RST_CODE      = 12'h000;

  // ------------------------------------------------------------
  // Bank shape and serial frame
  // ------------------------------------------------------------
  localparam int NUM_DAC     = 12;
  localparam int NUM_GROUP   = 4;               // A=0 B=1 C=2 D=3
  localparam int NUM_ALARM   = 16;              // Source 0 is the external pin
  localparam int CODE_W      = 12;
  localparam logic [4:0] FRAME_BITS = 5'h18;     // Command, address, data byte
  localparam logic [4:0] ADDR_DONE  = 5'h10;     // Bits taken when address is complete

  typedef logic [CODE_W-1:0] dacb_code_t;

  // Serial port pins as seen by the device
  typedef struct packed {
    logic csN;
    logic sclk;
    logic sdi;
  } dacb_spi_in_t;

  // Per-group analog range controls
  typedef struct packed {
    logic negative;
    logic halfSpan;
  } dacb_range_t;
endpackage
`default_nettype wire

// ==== verilog/dacb_bank.sv ====
// DAC bank control: serial register port, double-buffered codes, range and clear logic
//
// Operation
// - Twelve channels in groups A4 B2 C2 D4
// - Range and clamp shared within each group
// - Reset clamps outputs and defaults all code registers
// - Group polarity pin selects positive or negative
// - Positive groups may select half span
// - Straight binary codes at data addresses
// - Data write touches only the buffer
// - Update command copies buffer to active
// - Output follows active register only
// - Read select picks buffer or active
// - Clear drives zero code to core
// - Clear leaves buffer and active untouched
// - Data writes accepted during clear
// - Leaving clear restores active code at once
// - Per-channel software clear bits
// - External alarm pin can force clear
// - Alarm clears only if source enabled
// - Only marked channels respond to alarms
// - Alarm sets status bit, clears mapped channels
// - Release after status clear, no other alarm
`default_nettype none
module dacb_bank
(
  // Clock and reset
  input  wire  logic                                              clk,
  input  wire  logic                                              reset_n,
  // Serial register port
  input  wire  dacb_pkg::dacb_spi_in_t                            spiIn,
  output var   logic                                              sdo,
  output var   logic                                              sdoOe,
  // Group polarity pins and alarm sources
  input  wire  logic [dacb_pkg::NUM_GROUP-1:0]                    groupPolaritySelect,
  input  wire  logic                                              externalAlarmClearInput,
  input  wire  logic [dacb_pkg::NUM_ALARM-2:0]                    internalAlarm,
  // DAC core controls
  output var   dacb_pkg::dacb_code_t [dacb_pkg::NUM_DAC-1:0]      dacCore,
  output var   logic [dacb_pkg::NUM_DAC-1:0]                      dacClamp,
  output var   dacb_pkg::dacb_range_t [dacb_pkg::NUM_GROUP-1:0]   groupRange
);

  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  logic [2:0]                                  csSync_ff;
  logic [2:0]                                  sclkSync_ff;
  logic [1:0]                                  sdiSync_ff;
  logic [1:0]                                  extAlarmSync_ff;
  logic [dacb_pkg::NUM_GROUP-1:0]              polSync1_ff;
  logic [dacb_pkg::NUM_GROUP-1:0]              polSync2_ff;
  logic                                        sclkRise;
  logic                                        sclkFall;
  logic                                        csActive;
  logic [4:0]                                  bitCnt_ff;
  logic [23:0]                                 shiftIn_ff;
  logic [7:0]                                  readShift_ff;
  logic                                        isRead_ff;
  logic [7:0]                                  addr_ff;
  logic                                        wrStrobe;
  logic [7:0]                                  wrAddr;
  logic [7:0]                                  wrData;
  logic [7:0]                                  ifaceCfg_ff;
  logic [dacb_pkg::NUM_DAC-1:0]                clrEnable_ff;
  logic [dacb_pkg::NUM_ALARM-1:0]              clrSource_ff;
  logic [dacb_pkg::NUM_GROUP-1:0]              rangeSel_ff;
  logic [dacb_pkg::NUM_DAC-1:0]                swClear_ff;
  logic [dacb_pkg::NUM_ALARM-1:0]              alarmStatus_ff;
  logic [dacb_pkg::NUM_ALARM-1:0]              nxt_alarmStatus;
  logic [dacb_pkg::NUM_ALARM-1:0]              alarmEvent;
  logic [dacb_pkg::NUM_ALARM-1:0]              alarmClearMask;
  dacb_pkg::dacb_code_t [dacb_pkg::NUM_DAC-1:0] buffer_ff;
  dacb_pkg::dacb_code_t [dacb_pkg::NUM_DAC-1:0] active_ff;
  logic                                        updatePulse;
  logic                                        powerOnClamp_ff;
  logic                                        alarmClear;
  logic [dacb_pkg::NUM_DAC-1:0]                effClear;
  logic [7:0]                                  codeIdx;
  logic                                        codeHit;

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  // Serial pins cross into clk; edges are found on the settled stages only
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      csSync_ff   <= 3'h7;
      sclkSync_ff <= 3'h0;
      sdiSync_ff  <= 2'h0;
    end
    else
    begin
      csSync_ff   <= {csSync_ff[1:0], spiIn.csN};
      sclkSync_ff <= {sclkSync_ff[1:0], spiIn.sclk};
      sdiSync_ff  <= {sdiSync_ff[0], spiIn.sdi};
    end
  end

  // Alarm pin and polarity pins are plain levels
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      extAlarmSync_ff <= 2'h0;
      polSync1_ff     <= '0;
      polSync2_ff     <= '0;
    end
    else
    begin
      extAlarmSync_ff <= {extAlarmSync_ff[0], externalAlarmClearInput};
      polSync1_ff     <= groupPolaritySelect;
      polSync2_ff     <= polSync1_ff;
    end
  end

  assign sclkRise = sclkSync_ff[1] & ~sclkSync_ff[2];
  assign sclkFall = ~sclkSync_ff[1] & sclkSync_ff[2];
  assign csActive = ~csSync_ff[1];

  // ------------------------------------------------------------
  // Serial frame: read flag, address byte, data byte
  // ------------------------------------------------------------
  // Input sampled on SCLK rise; output changes on SCLK fall (mode 0)
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      bitCnt_ff    <= 5'h00;
      shiftIn_ff   <= 24'h000000;
      isRead_ff    <= 1'b0;
      addr_ff      <= 8'h00;
      readShift_ff <= 8'h00;
    end
    else if (!csActive)
    begin
      bitCnt_ff <= 5'h00;
      isRead_ff <= 1'b0;
    end
    else if (sclkRise && bitCnt_ff != dacb_pkg::FRAME_BITS)
    begin
      shiftIn_ff <= {shiftIn_ff[22:0], sdiSync_ff[1]};
      bitCnt_ff  <= bitCnt_ff + 5'h01;
      if (bitCnt_ff == dacb_pkg::ADDR_DONE - 5'h01)
      begin
        // Address complete: latch it and fetch the read byte
        addr_ff      <= {shiftIn_ff[6:0], sdiSync_ff[1]};
        isRead_ff    <= shiftIn_ff[14];
        readShift_ff <= rdDataFor({shiftIn_ff[6:0], sdiSync_ff[1]});
      end
    end
    else if (sclkFall && isRead_ff && bitCnt_ff >= dacb_pkg::ADDR_DONE)
    begin
      readShift_ff <= {readShift_ff[6:0], 1'b0};
    end
  end

  // Serial output pin and its enable, both registered
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sdo   <= 1'b0;
      sdoOe <= 1'b0;
    end
    else
    begin
      sdoOe <= csActive & isRead_ff;
      if (sclkFall && isRead_ff && bitCnt_ff >= dacb_pkg::ADDR_DONE)
        sdo <= readShift_ff[7];
    end
  end

  // A write frame commits once all its bits are in, on the last rise
  assign wrStrobe = csActive & sclkRise & ~isRead_ff & (bitCnt_ff == dacb_pkg::FRAME_BITS - 5'h01);
  assign wrAddr   = addr_ff;
  assign wrData   = {shiftIn_ff[6:0], sdiSync_ff[1]};
  assign codeIdx  = wrAddr - dacb_pkg::ADDR_CODE_FIRST;
  assign codeHit  = (wrAddr >= dacb_pkg::ADDR_CODE_FIRST) && (wrAddr <= dacb_pkg::ADDR_CODE_LAST);

  // ------------------------------------------------------------
  // Register read mux
  // ------------------------------------------------------------
  // Unmapped addresses read as zero; the update register always reads zero
  function automatic logic [7:0] rdDataFor(input logic [7:0] a);
    logic [7:0]              d;
    logic [7:0]              idx;
    dacb_pkg::dacb_code_t    code;
    d    = 8'h00;
    idx  = a - dacb_pkg::ADDR_CODE_FIRST;
    code = dacb_pkg::RST_CODE;
    case (a)
      dacb_pkg::ADDR_IFACE_CFG:     d = ifaceCfg_ff;
      dacb_pkg::ADDR_CLR_EN_LO:     d = clrEnable_ff[7:0];
      dacb_pkg::ADDR_CLR_EN_HI:     d = {4'h0, clrEnable_ff[11:8]};
      dacb_pkg::ADDR_CLR_SRC_LO:    d = clrSource_ff[7:0];
      dacb_pkg::ADDR_CLR_SRC_HI:    d = clrSource_ff[15:8];
      dacb_pkg::ADDR_RANGE:         d = {4'h0, rangeSel_ff};
      dacb_pkg::ADDR_ALARM_STAT_LO: d = alarmStatus_ff[7:0];
      dacb_pkg::ADDR_ALARM_STAT_HI: d = alarmStatus_ff[15:8];
      dacb_pkg::ADDR_SW_CLR_LO:     d = swClear_ff[7:0];
      dacb_pkg::ADDR_SW_CLR_HI:     d = {4'h0, swClear_ff[11:8]};
      default:
      begin
        if (a >= dacb_pkg::ADDR_CODE_FIRST && a <= dacb_pkg::ADDR_CODE_LAST)
        begin
          // Read select chooses the active or the buffered code
          code = ifaceCfg_ff[dacb_pkg::READ_SEL_BIT] ? active_ff[idx[4:1]] : buffer_ff[idx[4:1]];
          d    = idx[0] ? {4'h0, code[11:8]} : code[7:0];  // Straight binary, low byte first
        end
      end
    endcase
    return d;
  endfunction

  // ------------------------------------------------------------
  // Configuration registers
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ifaceCfg_ff  <= dacb_pkg::RST_BYTE;
      clrEnable_ff <= '0;
      clrSource_ff <= '0;
      rangeSel_ff  <= '0;
      swClear_ff   <= '0;
    end
    else if (wrStrobe)
    begin
      case (wrAddr)
        dacb_pkg::ADDR_IFACE_CFG:  ifaceCfg_ff <= wrData;
        dacb_pkg::ADDR_CLR_EN_LO:  clrEnable_ff[7:0] <= wrData;
        dacb_pkg::ADDR_CLR_EN_HI:  clrEnable_ff[11:8] <= wrData[3:0];
        dacb_pkg::ADDR_CLR_SRC_LO: clrSource_ff[7:0] <= wrData;
        dacb_pkg::ADDR_CLR_SRC_HI: clrSource_ff[15:8] <= wrData;
        dacb_pkg::ADDR_RANGE:      rangeSel_ff <= wrData[3:0];
        dacb_pkg::ADDR_SW_CLR_LO:  swClear_ff[7:0] <= wrData;
        dacb_pkg::ADDR_SW_CLR_HI:  swClear_ff[11:8] <= wrData[3:0];
        default:
        begin
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Alarm status
  // ------------------------------------------------------------
  // Source 0 is the external pin, the rest come from on-chip monitors
  assign alarmEvent = {internalAlarm, extAlarmSync_ff[1]};

  // Host clears with write-one; an alarm still present sets again at once
  always_comb
  begin
    alarmClearMask = '0;
    if (wrStrobe && wrAddr == dacb_pkg::ADDR_ALARM_STAT_LO)
      alarmClearMask[7:0] = wrData;
    if (wrStrobe && wrAddr == dacb_pkg::ADDR_ALARM_STAT_HI)
      alarmClearMask[15:8] = wrData;
    nxt_alarmStatus = (alarmStatus_ff & ~alarmClearMask) | alarmEvent;  // Set wins over clear
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      alarmStatus_ff <= '0;
    else
      alarmStatus_ff <= nxt_alarmStatus;
  end

  // ------------------------------------------------------------
  // Code registers: buffer and active
  // ------------------------------------------------------------
  assign updatePulse = wrStrobe & (wrAddr == dacb_pkg::ADDR_UPDATE) & wrData[dacb_pkg::UPDATE_BIT];

  // Writes land in the buffer only, clear state or not
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      buffer_ff <= '0;
    else if (wrStrobe && codeHit)
    begin
      if (codeIdx[0])
        buffer_ff[codeIdx[4:1]][11:8] <= wrData[3:0];
      else
        buffer_ff[codeIdx[4:1]][7:0] <= wrData;
    end
  end

  // Whole bank moves together so all outputs step in one cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      active_ff <= '0;
    else if (updatePulse)
      active_ff <= buffer_ff;
  end

  // Outputs stay at clamp from reset until the first update loads real codes
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      powerOnClamp_ff <= 1'b1;
    else if (updatePulse)
      powerOnClamp_ff <= 1'b0;
  end

  // ------------------------------------------------------------
  // Clear state and core drive
  // ------------------------------------------------------------
  // Any enabled source still flagged holds the alarm clear
  assign alarmClear = |(alarmStatus_ff & clrSource_ff);
  assign effClear   = swClear_ff | (clrEnable_ff & {dacb_pkg::NUM_DAC{alarmClear}});

  // Core sees zero code while cleared or power-on clamped, active code otherwise
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dacCore  <= '0;
      dacClamp <= '1;
    end
    else
    begin
      for (int ch = 0; ch < dacb_pkg::NUM_DAC; ch++)
      begin
        dacClamp[ch] <= powerOnClamp_ff;
        if (effClear[ch] || powerOnClamp_ff)
          dacCore[ch] <= dacb_pkg::RST_CODE;
        else
          dacCore[ch] <= active_ff[ch];       // Immediate restore
      end
    end
  end

  // Per-group range: polarity from pin, half span only when positive
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      groupRange <= '0;
    else
    begin
      for (int g = 0; g < dacb_pkg::NUM_GROUP; g++)
      begin
        groupRange[g].negative <= polSync2_ff[g];
        groupRange[g].halfSpan <= ~polSync2_ff[g] & rangeSel_ff[g];
      end
    end
  end

endmodule
`default_nettype wire

// ==== bench/dacb_bank_monitor.sv ====
// Port checker of the DAC bank
`default_nettype none
module dacb_bank_monitor
(
  // Clock and reset
  input wire logic                                          clk,
  input wire logic                                          reset_n,
  // Serial port
  input wire dacb_pkg::dacb_spi_in_t                        spiIn,
  input wire logic                                          sdo,
  input wire logic                                          sdoOe,
  // Pins
  input wire logic [dacb_pkg::NUM_GROUP-1:0]                groupPolaritySelect,
  input wire logic                                          externalAlarmClearInput,
  input wire logic [dacb_pkg::NUM_ALARM-2:0]                internalAlarm,
  // Core controls
  input wire dacb_pkg::dacb_code_t [dacb_pkg::NUM_DAC-1:0]  dacCore,
  input wire logic [dacb_pkg::NUM_DAC-1:0]                  dacClamp,
  input wire dacb_pkg::dacb_range_t [dacb_pkg::NUM_GROUP-1:0] groupRange
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0]                  sinceCs_ff;
  logic [4:0]                  sinceAlarm_ff;
  dacb_pkg::dacb_code_t [11:0] prevCore_ff;
  logic [3:0]                  negVec;
  logic [3:0]                  halfVec;
  logic                        nzChange;
  logic                        zrChange;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  // Saturating ages of the last frame and last alarm; they bound every cause
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sinceCs_ff <= 5'h1f;
      sinceAlarm_ff <= 5'h1f;
      prevCore_ff <= '0;
    end
    else
    begin
      sinceCs_ff <= !spiIn.csN ? 5'h00 : (sinceCs_ff == 5'h1f) ? 5'h1f : sinceCs_ff + 5'h01;
      sinceAlarm_ff <= (externalAlarmClearInput || |internalAlarm) ? 5'h00 :
                       (sinceAlarm_ff == 5'h1f) ? 5'h1f : sinceAlarm_ff + 5'h01;
      prevCore_ff <= dacCore;
    end
  end

  // Kinds of core change and flattened range fields
  always_comb
  begin
    nzChange = 1'b0;
    zrChange = 1'b0;
    for (int i = 0; i < 12; i++)
    begin
      nzChange |= (dacCore[i] != prevCore_ff[i]) && (dacCore[i] != 12'h000);
      zrChange |= (dacCore[i] != prevCore_ff[i]) && (dacCore[i] == 12'h000);
    end
    for (int g = 0; g < 4; g++)
    begin
      negVec[g] = groupRange[g].negative;
      halfVec[g] = groupRange[g].halfSpan;
    end
  end

  property p_reset_out;
    $rose(reset_n) |-> dacCore == '0 && dacClamp == '1;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("outputs not at reset values");
  property p_clamp_no_rise;
    (dacClamp & ~$past(dacClamp)) == '0;
  endproperty
  a_clamp_no_rise: assert property (p_clamp_no_rise) else $error("clamp raised again");
  property p_neg_follow;
    $stable(groupPolaritySelect) [*5] |-> negVec == groupPolaritySelect;
  endproperty
  a_neg_follow: assert property (p_neg_follow) else $error("polarity not from pin");
  property p_half_pos;
    (halfVec & negVec) == 4'h0;
  endproperty
  a_half_pos: assert property (p_half_pos) else $error("half span on negative group");
  property p_half_spi;
    $changed(halfVec) |-> sinceCs_ff < 5'h10 || $changed(negVec);
  endproperty
  a_half_spi: assert property (p_half_spi) else $error("span changed without write");
  property p_core_nonzero;
    nzChange |-> sinceCs_ff < 5'h10;
  endproperty
  a_core_nonzero: assert property (p_core_nonzero) else $error("code changed without command");
  property p_core_zero;
    zrChange |-> sinceCs_ff < 5'h10 || sinceAlarm_ff < 5'h08;
  endproperty
  a_core_zero: assert property (p_core_zero) else $error("clear without cause");
  property p_oe_frame;
    sdoOe |-> sinceCs_ff < 5'h05;
  endproperty
  a_oe_frame: assert property (p_oe_frame) else $error("sdo driven outside frame");
endmodule
`default_nettype wire

// ==== bench/dacb_host_model.sv ====
// Host model driving the serial register port in mode 0
`default_nettype none
module dacb_host_model
(
  // Clock
  input  wire logic                   clk,
  // Serial port
  output var  dacb_pkg::dacb_spi_in_t spiIn,
  input  wire logic                   sdo
);
  timeunit 1ns;
  timeprecision 1ps;

  // Idle: deselected, serial clock parked low
  initial spiIn = '{csN: 1'b1, sclk: 1'b0, sdi: 1'b0};

  // One 24-bit frame; serial clock of 8 clk, pins moved on falling clk edges
  task automatic xfer(input logic rd, input logic [7:0] adr, input logic [7:0] dat,
                      output logic [7:0] q);
    logic [23:0] sh;
    sh = {rd, 7'h00, adr, dat};
    q = 8'h00;
    @(negedge clk);
    spiIn.csN = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      spiIn.sdi = sh[i];
      repeat (4) @(negedge clk);
      spiIn.sclk = 1'b1;
      if (i < 8)
        q = {q[6:0], sdo};      // Sampled at the rise, long after the fall
      repeat (4) @(negedge clk);
      spiIn.sclk = 1'b0;
    end
    repeat (4) @(negedge clk);
    spiIn.csN = 1'b1;
    spiIn.sdi = ~spiIn.sdi;     // Stale bit never looks valid between frames
    repeat (4) @(negedge clk);
  endtask

  // Update command: buffer to active for all channels
  task automatic update();
    logic [7:0] q;
    xfer(1'b0, dacb_pkg::ADDR_UPDATE, 8'h01, q);
  endtask
endmodule
`default_nettype wire

// ==== bench/test_dacb_bank.sv ====
// Testbench of the DAC bank: register port, double buffering, range and clear paths
`default_nettype none
module test_dacb_bank;
  timeunit 1ns;
  timeprecision 1ps;
  logic                        clk;
  logic                        reset_n;
  dacb_pkg::dacb_spi_in_t      spiIn;
  logic                        sdo;
  logic                        sdoOe;
  logic [3:0]                  groupPolaritySelect;
  logic                        externalAlarmClearInput;
  logic [14:0]                 internalAlarm;
  dacb_pkg::dacb_code_t [11:0] dacCore;
  logic [11:0]                 dacClamp;
  dacb_pkg::dacb_range_t [3:0] groupRange;
  int                          error_cnt;
  int                          n_compared;

  dacb_bank dacb_bank_inst (.clk(clk), .reset_n(reset_n), .spiIn(spiIn), .sdo(sdo), .sdoOe(sdoOe),
    .groupPolaritySelect(groupPolaritySelect), .externalAlarmClearInput(externalAlarmClearInput),
    .internalAlarm(internalAlarm), .dacCore(dacCore), .dacClamp(dacClamp), .groupRange(groupRange));
  dacb_host_model dacb_host_model_inst (.clk(clk), .spiIn(spiIn), .sdo(sdo));

  // 250 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    dacb_host_model_inst.xfer(1'b0, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] q;
    dacb_host_model_inst.xfer(1'b1, a, 8'h00, q);
    chk({4'h0, q}, {4'h0, e});
    chk({11'h000, sdoOe}, 12'h000);
  endtask
  // Channel codes: mid-code on channel 0, full code on channel 11
  function automatic dacb_pkg::dacb_code_t code(input int n);
    return (n == 11) ? 12'hfff : 12'h800 + 12'(n) * 12'h0b1;
  endfunction
  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    reset_n = 1'b0;
    repeat (20) @(negedge clk);
    reset_n = 1'b1;
    repeat (4) @(negedge clk);
    for (int n = 0; n < 12; n++)
      chk(dacCore[n], 12'h000);
    chk(dacClamp, 12'hfff);
    rd(dacb_pkg::ADDR_CODE_FIRST, 8'h00);
    rd(dacb_pkg::ADDR_CLR_EN_LO, 8'h00);
    wr(8'h40, 8'hff);
    rd(8'h40, 8'h00);
    $display("reset test done");
  endtask

  task automatic t_range();
    logic [7:0] rv;
    groupPolaritySelect = 4'b0101;
    for (int r = 0; r < 2; r++)
    begin
      rv = r ? 8'h02 : 8'h0f;
      wr(dacb_pkg::ADDR_RANGE, rv);
      for (int g = 0; g < 4; g++)
        chk({10'h000, groupRange[g]}, {10'h000, groupPolaritySelect[g], rv[g] & ~groupPolaritySelect[g]});
    end
    $display("range test done");
  endtask

  task automatic t_update();
    dacb_pkg::dacb_code_t c;
    for (int n = 0; n < 12; n++)
    begin
      c = code(n);
      wr(dacb_pkg::ADDR_CODE_FIRST + 8'(2 * n), c[7:0]);
      wr(dacb_pkg::ADDR_CODE_FIRST + 8'(2 * n + 1), {4'h0, c[11:8]});
    end
    for (int n = 0; n < 12; n++)
      chk(dacCore[n], 12'h000);
    rd(dacb_pkg::ADDR_CODE_LAST, 8'h0f);
    wr(dacb_pkg::ADDR_IFACE_CFG, 8'h02);
    rd(dacb_pkg::ADDR_CODE_LAST, 8'h00);
    dacb_host_model_inst.update();
    for (int n = 0; n < 12; n++)
      chk(dacCore[n], code(n));
    chk(dacClamp, 12'h000);
    rd(dacb_pkg::ADDR_CODE_LAST, 8'h0f);
    $display("update test done");
  endtask

  task automatic t_swclr();
    wr(dacb_pkg::ADDR_SW_CLR_LO, 8'h01);
    wr(dacb_pkg::ADDR_SW_CLR_HI, 8'h08);
    chk(dacCore[0], 12'h000);
    chk(dacCore[11], 12'h000);
    chk(dacCore[1], code(1));
    wr(dacb_pkg::ADDR_CODE_FIRST, 8'h3c);
    wr(dacb_pkg::ADDR_CODE_FIRST + 8'h02, 8'h55);
    chk(dacCore[1], code(1));
    rd(dacb_pkg::ADDR_CODE_FIRST + 8'h01, 8'h08);
    wr(dacb_pkg::ADDR_IFACE_CFG, 8'h00);
    rd(dacb_pkg::ADDR_CODE_FIRST, 8'h3c);
    wr(dacb_pkg::ADDR_SW_CLR_LO, 8'h00);
    wr(dacb_pkg::ADDR_SW_CLR_HI, 8'h00);
    chk(dacCore[0], code(0));
    chk(dacCore[11], code(11));
    $display("software clear test done");
  endtask

  task automatic t_alarm();
    wr(dacb_pkg::ADDR_CLR_EN_LO, 8'h02);
    wr(dacb_pkg::ADDR_CLR_SRC_LO, 8'h02);
    externalAlarmClearInput = 1'b1;
    repeat (8) @(negedge clk);
    chk(dacCore[1], code(1));
    rd(dacb_pkg::ADDR_ALARM_STAT_LO, 8'h01);
    wr(dacb_pkg::ADDR_CLR_SRC_LO, 8'h03);
    chk(dacCore[1], 12'h000);
    chk(dacCore[2], code(2));
    internalAlarm[0] = 1'b1;
    externalAlarmClearInput = 1'b0;
    wr(dacb_pkg::ADDR_ALARM_STAT_LO, 8'h01);
    chk(dacCore[1], 12'h000);
    internalAlarm[0] = 1'b0;
    wr(dacb_pkg::ADDR_ALARM_STAT_LO, 8'h02);
    chk(dacCore[1], code(1));
    $display("alarm clear test done");
  endtask

  // Main sequence, ending with a reset in mid-run
  initial
  begin
    error_cnt = 0;
    n_compared = 0;
    reset_n = 1'b0;
    groupPolaritySelect = 4'h0;
    externalAlarmClearInput = 1'b0;
    internalAlarm = '0;
    t_reset();
    t_range();
    t_update();
    t_swclr();
    t_alarm();
    t_reset();
    give_verdict();
  end

  // Watchdog: nearly four times the expected run
  initial
  begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    give_verdict();
  end
endmodule

bind dacb_bank dacb_bank_monitor dacb_bank_monitor_inst (.clk(clk), .reset_n(reset_n), .spiIn(spiIn),
  .sdo(sdo), .sdoOe(sdoOe), .groupPolaritySelect(groupPolaritySelect),
  .externalAlarmClearInput(externalAlarmClearInput), .internalAlarm(internalAlarm),
  .dacCore(dacCore), .dacClamp(dacClamp), .groupRange(groupRange));
`default_nettype wire
